// ### rtl/fms_pkg.sv
`default_nettype none
package fms_pkg;
  // List storage
  localparam int unsigned LIST_DEPTH   = 512;
  localparam int unsigned PTR_W        = 9;
  localparam int unsigned CNT_W        = 10;
  localparam int unsigned ADDR_W       = 12;
  // Register indices; byte address is four times the index
  localparam logic [9:0]  IDX_MFR_ID     = 10'h000;
  localparam logic [9:0]  IDX_DEV_TYPE   = 10'h001;
  localparam logic [9:0]  IDX_STATUS_CTL = 10'h004;
  localparam logic [9:0]  IDX_SCAN_CTL   = 10'h006;
  localparam logic [9:0]  IDX_SCAN_CFG   = 10'h008;
  localparam logic [9:0]  IDX_SCAN_STAT  = 10'h009;
  // Status/control bits
  localparam int unsigned STC_DIRECT_BIT = 3;
  localparam int unsigned STC_START_BIT  = 4;
  // Scan control bits
  localparam int unsigned SCC_CLEAR_BIT  = 0;
  localparam int unsigned SCC_DBUS_BIT   = 1;
  localparam int unsigned SCC_CONT_BIT   = 3;
  localparam int unsigned SCC_PTR_RST_BIT = 4;
  // Entry layout in the channel configuration word
  localparam int unsigned CFG_MEAS_LSB   = 0;
  localparam int unsigned CFG_TREE_B_BIT = 2;
  localparam int unsigned CFG_TREE_A_BIT = 3;
  localparam int unsigned CFG_VALID_N_BIT = 4;
  localparam int unsigned CFG_CHAN_LSB   = 8;
  // Scan status readout layout
  localparam int unsigned SST_PTR_LSB    = 16;
  localparam int unsigned SST_RUN_BIT    = 28;
  localparam int unsigned SST_FULL_BIT   = 29;
  // Reset values
  localparam logic [15:0] STATUS_CTL_RST = 16'h0000;
  localparam logic [15:0] SCAN_CTL_RST   = 16'h0000;
  // Bus responses
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_DECERR    = 2'h3;

  typedef enum logic [1:0] {
    MEAS_VOLTS = 2'b00,
    MEAS_OHMS2 = 2'b01,
    MEAS_OHMS4 = 2'b11,
    MEAS_THERM = 2'b10
  } fms_meas_t;

  typedef struct packed {
    logic [3:0] chan;
    logic       valid_n;
    logic       tree_a_en;
    logic       tree_b_en;
    fms_meas_t  meas;
  } fms_entry_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0]       data;
    logic [3:0]        strb;
  } fms_wr_req_t;

  // Gray along idle, run, halt
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_HALT = 2'b11
  } fms_scan_st_t;
endpackage
`default_nettype wire

// ### rtl/fms_list_ram.sv
`default_nettype none
module fms_list_ram #(
  parameter int unsigned DEPTH = fms_pkg::LIST_DEPTH,
  parameter int unsigned AW    = fms_pkg::PTR_W
) (
  input  wire logic               clk_sys_i,
  input  wire logic               wr_en_i,
  input  wire logic [AW-1:0]      wr_addr_i,
  input  wire fms_pkg::fms_entry_t wr_data_i,
  input  wire logic [AW-1:0]      rd_addr_i,
  output fms_pkg::fms_entry_t     rd_data_o
);
  fms_pkg::fms_entry_t mem [DEPTH];

  // No reset on the array; occupancy is tracked by the owner
  always_ff @(posedge clk_sys_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= mem[rd_addr_i];
  end
endmodule
`default_nettype wire

// ### rtl/fms_axil_slave.sv
`default_nettype none
module fms_axil_slave (
  input  wire logic                         clk_sys_i,
  input  wire logic                         arst_n_i,
  input  wire logic [fms_pkg::ADDR_W-1:0]   s_axi_awaddr_i,
  input  wire logic                         s_axi_awvalid_i,
  output logic                              s_axi_awready_o,
  input  wire logic [31:0]                  s_axi_wdata_i,
  input  wire logic [3:0]                   s_axi_wstrb_i,
  input  wire logic                         s_axi_wvalid_i,
  output logic                              s_axi_wready_o,
  output logic [1:0]                        s_axi_bresp_o,
  output logic                              s_axi_bvalid_o,
  input  wire logic                         s_axi_bready_i,
  input  wire logic [fms_pkg::ADDR_W-1:0]   s_axi_araddr_i,
  input  wire logic                         s_axi_arvalid_i,
  output logic                              s_axi_arready_o,
  output logic [31:0]                       s_axi_rdata_o,
  output logic [1:0]                        s_axi_rresp_o,
  output logic                              s_axi_rvalid_o,
  input  wire logic                         s_axi_rready_i,
  output logic                              wr_en_o,
  output fms_pkg::fms_wr_req_t              wr_req_o,
  input  wire logic                         wr_err_i,
  output logic [fms_pkg::ADDR_W-1:0]        rd_addr_o,
  input  wire logic [31:0]                  rd_data_i,
  input  wire logic                         rd_err_i
);
  logic aw_held_q;
  logic w_held_q;

  // Address and data may arrive in either order; each is held until both are in
  assign s_axi_awready_o = !aw_held_q && !s_axi_bvalid_o;
  assign s_axi_wready_o  = !w_held_q && !s_axi_bvalid_o;
  assign wr_en_o         = aw_held_q && w_held_q && !s_axi_bvalid_o;

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      wr_req_o  <= '0;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_held_q     <= 1'b1;
        wr_req_o.addr <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_held_q      <= 1'b1;
        wr_req_o.data <= s_axi_wdata_i;
        wr_req_o.strb <= s_axi_wstrb_i;
      end
      if (wr_en_o) begin
        aw_held_q <= 1'b0;
        w_held_q  <= 1'b0;
      end
    end
  end

  // Write response raised on the same edge as the register update
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= fms_pkg::RESP_OKAY;
    end else if (wr_en_o) begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o  <= wr_err_i ? fms_pkg::RESP_DECERR : fms_pkg::RESP_OKAY;
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  // Reads answer on the same edge that takes the address
  assign s_axi_arready_o = !s_axi_rvalid_o;
  assign rd_addr_o       = s_axi_araddr_i;

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o  <= 32'h0000_0000;
      s_axi_rresp_o  <= fms_pkg::RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o  <= rd_err_i ? 32'h0000_0000 : rd_data_i;
      s_axi_rresp_o  <= rd_err_i ? fms_pkg::RESP_DECERR : fms_pkg::RESP_OKAY;
    end else if (s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### rtl/fms_scan_seq.sv
// What this block does
// R01: The list holds at most 512 entries.
// R02: Raising the clear bit empties the previously loaded list.
// R03: Software clears direct mode before loading the list.
// R04: Every configuration write to a list that is not full, with clear released, appends exactly one entry.
// R05: Each conversion-done pulse during a bus-triggered scan moves the list on by one entry.
// R06: Only entries flagged valid close a channel on this card.
// R07: Software loads the full list into every card, differing in valid flag.
// R08: Writing 26 to scan control enables bus trigger, continuous scan, rewinds pointer.
// R09: Direct mode on 8, off on 0; writing 16 closes the first channel.
// R10: Once armed, every pulse advances without software until a one-pass list halts after its last entry.
// R11: The pulse is ignored unless bus triggering is enabled.
// R12: In continuous mode stepping past the last entry wraps to the first.
// R13: The list cannot be read back.
// R14: Identification registers return fixed values.
// R15: The voltmeter pulses after every completed reading.
// R16: Valid flag is active low.
// R17: Four-bit channel number selects channel 0 to 15, bit 0 lowest.
// R18: Measurement code: volts 00, 2-wire 01, 4-wire 11, thermistor 10.
// R19: Both tree enables set connect the analog bus; both clear disconnect.
// R20: A write to a full list is dropped and changes nothing.
// R21: Invalid active entry opens all channels but pointer still steps.
//
// Register access over AXI4-Lite is this design's own decision.
`default_nettype none
module fms_scan_seq #(
  parameter logic [15:0] MFR_ID     = 16'h0A5A,  // Arbitrary identification value
  parameter logic [15:0] DEV_TYPE   = 16'h0C3C,  // Arbitrary identification value
  parameter int unsigned LIST_DEPTH = fms_pkg::LIST_DEPTH
) (
  input  wire logic                         clk_sys_i,
  input  wire logic                         arst_n_i,
  input  wire logic [fms_pkg::ADDR_W-1:0]   s_axi_awaddr_i,
  input  wire logic                         s_axi_awvalid_i,
  output logic                              s_axi_awready_o,
  input  wire logic [31:0]                  s_axi_wdata_i,
  input  wire logic [3:0]                   s_axi_wstrb_i,
  input  wire logic                         s_axi_wvalid_i,
  output logic                              s_axi_wready_o,
  output logic [1:0]                        s_axi_bresp_o,
  output logic                              s_axi_bvalid_o,
  input  wire logic                         s_axi_bready_i,
  input  wire logic [fms_pkg::ADDR_W-1:0]   s_axi_araddr_i,
  input  wire logic                         s_axi_arvalid_i,
  output logic                              s_axi_arready_o,
  output logic [31:0]                       s_axi_rdata_o,
  output logic [1:0]                        s_axi_rresp_o,
  output logic                              s_axi_rvalid_o,
  input  wire logic                         s_axi_rready_i,
  input  wire logic                         conversion_done_pulse_i,
  output logic [15:0]                       channel_close_o,
  output logic [1:0]                        measure_config_o,
  output logic                              tree_a_en_o,
  output logic                              tree_b_en_o,
  output logic                              scan_running_o
);
  localparam logic [fms_pkg::CNT_W-1:0] FULL_CNT = fms_pkg::CNT_W'(LIST_DEPTH);

  logic                          wr_en;
  fms_pkg::fms_wr_req_t          wr_req;
  logic                          wr_err;
  logic [fms_pkg::ADDR_W-1:0]    rd_addr;
  logic [31:0]                   rd_data;
  logic                          rd_err;
  logic [9:0]                    wr_idx;
  logic [9:0]                    rd_idx;
  logic [15:0]                   stc_q;
  logic [15:0]                   scc_q;
  logic [15:0]                   wr_mask;
  logic [fms_pkg::CNT_W-1:0]     count_q;
  logic [fms_pkg::PTR_W-1:0]     ptr_q;
  logic                          done_q;
  logic                          done_rise;
  logic                          advance;
  logic                          at_last;
  logic                          list_full;
  logic                          append;
  logic                          stc_wr;
  logic                          scc_wr;
  logic                          cfg_wr;
  logic                          start_req;
  logic                          rewind_req;
  fms_pkg::fms_entry_t           new_entry;
  fms_pkg::fms_entry_t           entry;
  fms_pkg::fms_scan_st_t         state_q;

  fms_axil_slave u_bus (
    .clk_sys_i       (clk_sys_i),
    .arst_n_i        (arst_n_i),
    .s_axi_awaddr_i  (s_axi_awaddr_i),
    .s_axi_awvalid_i (s_axi_awvalid_i),
    .s_axi_awready_o (s_axi_awready_o),
    .s_axi_wdata_i   (s_axi_wdata_i),
    .s_axi_wstrb_i   (s_axi_wstrb_i),
    .s_axi_wvalid_i  (s_axi_wvalid_i),
    .s_axi_wready_o  (s_axi_wready_o),
    .s_axi_bresp_o   (s_axi_bresp_o),
    .s_axi_bvalid_o  (s_axi_bvalid_o),
    .s_axi_bready_i  (s_axi_bready_i),
    .s_axi_araddr_i  (s_axi_araddr_i),
    .s_axi_arvalid_i (s_axi_arvalid_i),
    .s_axi_arready_o (s_axi_arready_o),
    .s_axi_rdata_o   (s_axi_rdata_o),
    .s_axi_rresp_o   (s_axi_rresp_o),
    .s_axi_rvalid_o  (s_axi_rvalid_o),
    .s_axi_rready_i  (s_axi_rready_i),
    .wr_en_o         (wr_en),
    .wr_req_o        (wr_req),
    .wr_err_i        (wr_err),
    .rd_addr_o       (rd_addr),
    .rd_data_i       (rd_data),
    .rd_err_i        (rd_err)
  );

  // Write decode; byte address bits 1:0 are ignored
  assign wr_idx  = wr_req.addr[11:2];
  assign wr_mask = {{8{wr_req.strb[1]}}, {8{wr_req.strb[0]}}};

  always_comb begin
    stc_wr = 1'b0;
    scc_wr = 1'b0;
    cfg_wr = 1'b0;
    wr_err = 1'b0;
    if (wr_idx == fms_pkg::IDX_STATUS_CTL) begin
      stc_wr = wr_en;
    end else if (wr_idx == fms_pkg::IDX_SCAN_CTL) begin
      scc_wr = wr_en;
    end else if (wr_idx == fms_pkg::IDX_SCAN_CFG) begin
      cfg_wr = wr_en;
    end else if (wr_idx == fms_pkg::IDX_MFR_ID || wr_idx == fms_pkg::IDX_DEV_TYPE ||
                 wr_idx == fms_pkg::IDX_SCAN_STAT) begin
      wr_err = 1'b0;  // Read-only registers swallow writes quietly
    end else begin
      wr_err = 1'b1;
    end
  end

  // Action bits act only on the write that carries them
  assign start_req  = stc_wr && wr_req.strb[0] && wr_req.data[fms_pkg::STC_START_BIT];    // see R09
  assign rewind_req = scc_wr && wr_req.strb[0] && wr_req.data[fms_pkg::SCC_PTR_RST_BIT]; // see R08

  // Status/control: direct mode level; start bit never stored, reads back zero
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      stc_q <= fms_pkg::STATUS_CTL_RST;
    end else if (stc_wr) begin
      stc_q <= (stc_q & ~wr_mask) | (wr_req.data[15:0] & wr_mask & ~(16'h0001 << fms_pkg::STC_START_BIT));
    end
  end

  // Scan control: clear, bus trigger and continuous enables; rewind is a pulse
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      scc_q <= fms_pkg::SCAN_CTL_RST;
    end else if (scc_wr) begin
      scc_q <= (scc_q & ~wr_mask) | (wr_req.data[15:0] & wr_mask & ~(16'h0001 << fms_pkg::SCC_PTR_RST_BIT));
    end
  end

  // Entry fields taken from the configuration word
  always_comb begin
    new_entry.chan      = wr_req.data[fms_pkg::CFG_CHAN_LSB +: 4];         // see R17
    new_entry.valid_n   = wr_req.data[fms_pkg::CFG_VALID_N_BIT];
    new_entry.tree_a_en = wr_req.data[fms_pkg::CFG_TREE_A_BIT];
    new_entry.tree_b_en = wr_req.data[fms_pkg::CFG_TREE_B_BIT];
    new_entry.meas      = fms_pkg::fms_meas_t'(wr_req.data[fms_pkg::CFG_MEAS_LSB +: 2]);
  end

  assign list_full = (count_q == FULL_CNT);                                    // see R01
  // Holding clear keeps the list empty, so loading waits for its release
  assign append    = cfg_wr && !list_full && !scc_q[fms_pkg::SCC_CLEAR_BIT];   // see R04 see R20

  // Occupancy count
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      count_q <= '0;
    end else if (scc_q[fms_pkg::SCC_CLEAR_BIT]) begin
      count_q <= '0;                                                           // see R02
    end else if (append) begin
      count_q <= count_q + fms_pkg::CNT_W'(1);                                 // see R04
    end
  end

  fms_list_ram #(
    .DEPTH (LIST_DEPTH),
    .AW    (fms_pkg::PTR_W)
  ) u_list (
    .clk_sys_i (clk_sys_i),
    .wr_en_i   (append),
    .wr_addr_i (count_q[fms_pkg::PTR_W-1:0]),
    .wr_data_i (new_entry),
    .rd_addr_i (ptr_q),
    .rd_data_o (entry)
  );

  // Edge detect so a long pulse counts once
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      done_q <= 1'b0;
    end else begin
      done_q <= conversion_done_pulse_i;
    end
  end

  assign done_rise = conversion_done_pulse_i && !done_q;
  assign at_last   = ({1'b0, ptr_q} == count_q - fms_pkg::CNT_W'(1));
  // Pulse only counts while bus triggering is on and a list is running
  assign advance   = done_rise && scc_q[fms_pkg::SCC_DBUS_BIT] && (state_q == fms_pkg::ST_RUN)
                     && (count_q != '0);                                       // see R11 see R10

  // Scan pointer; rewind wins over an advance in the same cycle
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ptr_q <= '0;
    end else if (rewind_req || scc_q[fms_pkg::SCC_CLEAR_BIT]) begin
      ptr_q <= '0;                                                             // see R08
    end else if (advance) begin
      if (at_last) begin
        ptr_q <= '0;                                                           // see R12
      end else begin
        ptr_q <= ptr_q + fms_pkg::PTR_W'(1);                                   // see R05
      end
    end
  end

  // Scan state: run after start, halt after the last entry unless continuous
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q <= fms_pkg::ST_IDLE;
    end else if (stc_q[fms_pkg::STC_DIRECT_BIT] || scc_q[fms_pkg::SCC_CLEAR_BIT]) begin
      state_q <= fms_pkg::ST_IDLE;
    end else begin
      case (state_q)
        fms_pkg::ST_IDLE: begin
          if (start_req && !wr_req.data[fms_pkg::STC_DIRECT_BIT]) begin
            state_q <= fms_pkg::ST_RUN;                                        // see R09
          end
        end
        fms_pkg::ST_RUN: begin
          if (advance && at_last && !scc_q[fms_pkg::SCC_CONT_BIT] && !rewind_req) begin
            state_q <= fms_pkg::ST_HALT;
          end
        end
        fms_pkg::ST_HALT: begin
          if (start_req) begin
            state_q <= fms_pkg::ST_RUN;
          end
        end
        default: begin
          state_q <= fms_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Channel drive; entry lags pointer by one cycle through the list memory
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      channel_close_o  <= 16'h0000;
      measure_config_o <= fms_pkg::MEAS_VOLTS;
      tree_a_en_o      <= 1'b0;
      tree_b_en_o      <= 1'b0;
    end else if (state_q == fms_pkg::ST_RUN && !entry.valid_n) begin          // see R06 see R16
      channel_close_o  <= 16'h0001 << entry.chan;                              // see R17
      measure_config_o <= entry.meas;                                          // see R18
      tree_a_en_o      <= entry.tree_a_en;                                     // see R19
      tree_b_en_o      <= entry.tree_b_en;
    end else begin
      channel_close_o  <= 16'h0000;                                            // see R21
      measure_config_o <= fms_pkg::MEAS_VOLTS;
      tree_a_en_o      <= 1'b0;
      tree_b_en_o      <= 1'b0;
    end
  end

  assign scan_running_o = (state_q == fms_pkg::ST_RUN);

  // Read decode; list contents are never returned
  assign rd_idx = rd_addr[11:2];

  always_comb begin
    rd_data = 32'h0000_0000;
    rd_err  = 1'b0;
    if (rd_idx == fms_pkg::IDX_MFR_ID) begin
      rd_data[15:0] = MFR_ID;                                                  // see R14
    end else if (rd_idx == fms_pkg::IDX_DEV_TYPE) begin
      rd_data[15:0] = DEV_TYPE;                                                // see R14
    end else if (rd_idx == fms_pkg::IDX_STATUS_CTL) begin
      rd_data[15:0] = stc_q;
    end else if (rd_idx == fms_pkg::IDX_SCAN_CTL) begin
      rd_data[15:0] = scc_q;
    end else if (rd_idx == fms_pkg::IDX_SCAN_CFG) begin
      rd_data = 32'h0000_0000;                                                 // see R13
    end else if (rd_idx == fms_pkg::IDX_SCAN_STAT) begin
      rd_data[fms_pkg::CNT_W-1:0]                     = count_q;
      rd_data[fms_pkg::SST_PTR_LSB +: fms_pkg::PTR_W] = ptr_q;
      rd_data[fms_pkg::SST_RUN_BIT]                   = scan_running_o;
      rd_data[fms_pkg::SST_FULL_BIT]                  = list_full;
    end else begin
      rd_err = 1'b1;
    end
  end

  // Checks
  sequence s_step;
    advance && !rewind_req && !scc_q[fms_pkg::SCC_CLEAR_BIT];
  endsequence

  sequence s_clear_then_load;
    scc_q[fms_pkg::SCC_CLEAR_BIT] ##1 !scc_q[fms_pkg::SCC_CLEAR_BIT];
  endsequence

  list_cap_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i) // see R01
    count_q <= FULL_CNT) else $error("list count above capacity");

  clear_empty_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i) // see R02
    s_clear_then_load |-> count_q == '0 && ptr_q == '0) else $error("clear left entries");

  append_one_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i) // see R04
    append |=> count_q == $past(count_q) + fms_pkg::CNT_W'(1)) else $error("append not one entry");

  full_drop_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i) // see R20
    cfg_wr && list_full |=> $stable(count_q)) else $error("write to full list changed count");

  step_one_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i) // see R05
    s_step ##0 !at_last |=> ptr_q == $past(ptr_q) + fms_pkg::PTR_W'(1)) else $error("pointer did not step");

  wrap_first_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i) // see R12
    s_step ##0 at_last && scc_q[fms_pkg::SCC_CONT_BIT] |=> ptr_q == '0 && scan_running_o)
    else $error("continuous scan did not wrap");

  dbus_gate_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i) // see R11
    !scc_q[fms_pkg::SCC_DBUS_BIT] && !rewind_req && !scc_q[fms_pkg::SCC_CLEAR_BIT] |=> $stable(ptr_q))
    else $error("pointer moved with bus trigger off");

  rewind_ptr_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i) // see R08
    rewind_req |=> ptr_q == '0 ##2 ptr_q <= fms_pkg::PTR_W'(2)) else $error("rewind did not reset pointer");

  valid_close_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i) // see R06
    channel_close_o != 16'h0000 |-> $past(!entry.valid_n) && channel_close_o == 16'h0001 << $past(entry.chan)
    && $onehot(channel_close_o)) else $error("channel closed from invalid entry");

  invalid_open_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i) // see R21
    entry.valid_n |=> channel_close_o == 16'h0000 && !tree_a_en_o && !tree_b_en_o)
    else $error("invalid entry left a channel closed");
endmodule
`default_nettype wire

// ### rtl/fms_pad.sv
`default_nettype none
`default_nettype wire

// ### sim/fms_vm_model.sv
`default_nettype none
module fms_vm_model (
  input  wire logic       clk_sys_i,
  input  wire logic       arst_n_i,
  input  wire logic       read_req_i,
  input  wire logic [3:0] delay_i,
  output logic            conversion_done_pulse_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] cnt_q;
  // Reading time then one done pulse; line idles low between readings
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_q <= 5'h00;
      conversion_done_pulse_o <= 1'b0;
    end else begin
      conversion_done_pulse_o <= (cnt_q == 5'h01);
      if (read_req_i) cnt_q <= {1'b0, delay_i} + 5'h01;
      else if (cnt_q != 5'h00) cnt_q <= cnt_q - 5'h01;
    end
  end
endmodule
`default_nettype wire

// ### sim/test_fet_mux_scan_list_sequencer.sv
`default_nettype none
module test_fet_mux_scan_list_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys_i = 0, arst_n_i = 0, go = 0, pls, tra, trb, run;
  logic        awv = 0, wv = 0, br = 0, arv = 0, rr = 0, awr, wr_r, bv, arr, rv;
  logic [11:0] awa = 12'h000, ara = 12'h000;
  logic [31:0] wd = 32'h0, rd_d, rdat;
  logic [1:0]  br_s, rr_s, rsp, bsp, meas;
  logic [15:0] cls;
  logic [3:0]  ch [4] = '{4'h3, 4'h5, 4'hF, 4'h0};
  logic        vn [4] = '{1'b0, 1'b1, 1'b0, 1'b0};
  logic [1:0]  ms [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
  int          err_count = 0, cmp_count = 0;
  fms_scan_seq fms_scan_seq_i (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .s_axi_awaddr_i(awa),
    .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF),
    .s_axi_wvalid_i(wv), .s_axi_wready_o(wr_r), .s_axi_bresp_o(br_s), .s_axi_bvalid_o(bv),
    .s_axi_bready_i(br), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
    .s_axi_rdata_o(rd_d), .s_axi_rresp_o(rr_s), .s_axi_rvalid_o(rv), .s_axi_rready_i(rr),
    .conversion_done_pulse_i(pls), .channel_close_o(cls), .measure_config_o(meas),
    .tree_a_en_o(tra), .tree_b_en_o(trb), .scan_running_o(run));
  fms_vm_model fms_vm_model_i (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .read_req_i(go),
    .delay_i(4'h3), .conversion_done_pulse_o(pls));
  // Clock at 125 MHz
  initial forever #4 clk_sys_i = ~clk_sys_i;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Requests stand until a rising edge sees ready; the answer is taken at the first later edge that sees valid
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; br <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr_r) wv <= 1'b0;
      bsp = br_s;
    end while (!bv);
    br <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge clk_sys_i);
    ara <= a; arv <= 1'b1; rr <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      if (arv && arr) arv <= 1'b0;
      rdat = rd_d;
      rsp = rr_s;
    end while (!rv);
    rr <= 1'b0;
  endtask
  task automatic pulse();
    @(posedge clk_sys_i) go <= 1'b1;
    @(posedge clk_sys_i) go <= 1'b0;
    repeat (12) @(posedge clk_sys_i);
  endtask
  task automatic look(input int k);
    chk(cls, vn[k] ? 16'h0000 : 16'h0001 << ch[k]);
    chk(meas, vn[k] ? 2'h0 : ms[k]);
    chk({tra, trb}, vn[k] ? 2'h0 : 2'h3);
  endtask
  task automatic t_ident();
    wr(12'h000, 32'hFFFF); chk(bsp, fms_pkg::RESP_OKAY);
    rd(12'h000); chk(rdat, 32'h0A5A);
    rd(12'h004); chk(rdat, 32'h0C3C);
    rd(12'h03C); chk(rsp, fms_pkg::RESP_DECERR);
    wr(12'h03C, 32'h0); chk(bsp, fms_pkg::RESP_DECERR);
  endtask
  task automatic t_load();
    wr(12'h018, 32'h1); wr(12'h018, 32'h0); wr(12'h010, 32'h0);
    for (int k = 0; k < 4; k++) wr(12'h020, {ch[k], 3'h0, vn[k], 2'h3, ms[k]});
    rd(12'h024); chk(rdat[9:0], 10'h004);
    rd(12'h020); chk(rdat, 32'h0);
  endtask
  task automatic t_arm();
    wr(12'h010, 32'd8); wr(12'h018, 32'd26); wr(12'h010, 32'd0); wr(12'h010, 32'd16);
    repeat (4) @(posedge clk_sys_i);
    chk(run, 1'b1); look(0);
  endtask
  // Four pulses walk the list and wrap to its head
  task automatic t_step();
    for (int k = 1; k < 5; k++) begin
      pulse(); look(k % 4);
    end
  endtask
  task automatic t_gate();
    wr(12'h018, 32'h8); pulse();
    rd(12'h024); chk(rdat[24:16], 9'h000);
    // Direct mode opens everything; then a one-pass list halts after its last entry
    wr(12'h010, 32'd8);
    repeat (2) @(posedge clk_sys_i);
    chk(run, 1'b0); chk(cls, 32'h0);
    wr(12'h010, 32'd0); wr(12'h010, 32'd16); wr(12'h018, 32'h2);
    for (int k = 0; k < 4; k++) pulse();
    chk(run, 1'b0); chk(cls, 32'h0);
  endtask
  task automatic t_full();
    wr(12'h018, 32'h1); rd(12'h024); chk(rdat[9:0], 10'h000);
    wr(12'h018, 32'h0);
    for (int i = 0; i < 513; i++) wr(12'h020, 32'h0);
    rd(12'h024); chk(rdat[29], 1'b1); chk(rdat[9:0], 10'd512);
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Watchdog well beyond the roughly 2300 cycles the tests take
  initial begin
    #400000;
    err_count++;
    final_report();
  end
  initial begin
    repeat (20) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    t_ident(); t_load(); t_arm(); t_step(); t_gate(); t_full();
    final_report();
  end
endmodule
`default_nettype wire
